// *** dv/low_power_clock_gating_test.sv ***
// Self-checking bench for the power mode clock gating block.
// Assumes a core model issues requests; the bench drives wake and keeps.
`timescale 1ns/100ps

module low_power_clock_gating_test;
    logic clk, rst_b, go, wakeEvent, busClockTick, bus_clock_out;
    logic modeAck, crystal_input_en;
    logic [1:0] goMode, modeReq;
    logic [7:0] waitPeriphKeep, periphClkEn;
    lpcg_pkg::lpcg_clk_en_t clkEn;
    int num_errors, n_tests;

    lpcg_core_model lpcg_core_model_i (.clk(clk), .rst_b(rst_b), .go(go),
        .goMode(goMode), .modeAck(modeAck), .modeReq(modeReq));
    lpcg_top #(.PERIPH_N(8)) lpcg_top_i (.clk(clk), .rst_b(rst_b),
        .modeReq(modeReq), .wakeEvent(wakeEvent),
        .waitPeriphKeep(waitPeriphKeep), .modeAck(modeAck), .clkEn(clkEn),
        .periphClkEn(periphClkEn), .busClockTick(busClockTick),
        .bus_clock_out(bus_clock_out), .crystal_input_en(crystal_input_en));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Checks and expectations
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("errors=%0d compares=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    function automatic logic [2:0] exp_en(input logic [1:0] m);
        case (m)
            lpcg_pkg::LPCG_REQ_WAIT: return 3'h3;
            lpcg_pkg::LPCG_REQ_PSTOP: return 3'h1;
            lpcg_pkg::LPCG_REQ_STOP: return 3'h0;
            default: return 3'h7;
        endcase
    endfunction

    function automatic logic [7:0] exp_per(input logic [1:0] m,
        input logic [7:0] k);
        if (m == lpcg_pkg::LPCG_REQ_RUN)
            return 8'hff;
        return (m == lpcg_pkg::LPCG_REQ_WAIT) ? k : 8'h00;
    endfunction

    // Run and Wait toggle every clk; gated modes rest low, no runt pulse
    task automatic bus_chk(input logic [1:0] m);
        logic prev;
        repeat (4)
        begin
            prev = bus_clock_out;
            @(posedge clk);
            #1;
            chk({7'h0, bus_clock_out}, {7'h0, exp_en(m) == 3'h0 ||
                exp_en(m) == 3'h1 ? 1'b0 : ~prev});
            chk({7'h0, busClockTick}, {7'h0, exp_en(m) == 3'h0 ||
                exp_en(m) == 3'h1 ? 1'b0 : prev});
        end
    endtask

    task automatic state_chk(input logic [1:0] m, input logic [7:0] k);
        chk({5'h0, clkEn}, {5'h0, exp_en(m)});
        chk(periphClkEn, exp_per(m, k));
        chk({7'h0, crystal_input_en},
            {7'h0, m != lpcg_pkg::LPCG_REQ_STOP});
        chk({7'h0, modeAck}, {7'h0, m != lpcg_pkg::LPCG_REQ_RUN});
        bus_chk(m);
    endtask

    // ------------------------------------------------------------
    // One full Run, mode, wake, Run round trip
    // ------------------------------------------------------------
    task automatic run_mode(input logic [1:0] m, input logic [7:0] k);
        int i;
        @(posedge clk);
        go <= 1'b1;
        goMode <= m;
        waitPeriphKeep <= k;
        @(posedge clk);
        go <= 1'b0;
        i = 0;
        do
        begin
            @(posedge clk);
            #1;
            i++;
        end
        while (modeAck !== 1'b1 && i < 8);
        if (modeAck !== 1'b1)
        begin
            num_errors++;
            summarize();
        end
        state_chk(m, k);
        @(posedge clk);
        wakeEvent <= 1'b1;
        @(posedge clk);
        wakeEvent <= 1'b0;
        #1;
        state_chk(lpcg_pkg::LPCG_REQ_RUN, k);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        go = 1'b0;
        goMode = 2'h0;
        wakeEvent = 1'b0;
        waitPeriphKeep = 8'h00;
        num_errors = 0;
        n_tests = 0;
        void'($urandom(19));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        state_chk(lpcg_pkg::LPCG_REQ_RUN, 8'h00);
        run_mode(lpcg_pkg::LPCG_REQ_WAIT, 8'h00);
        run_mode(lpcg_pkg::LPCG_REQ_WAIT, 8'hff);
        run_mode(lpcg_pkg::LPCG_REQ_PSTOP, 8'ha5);
        run_mode(lpcg_pkg::LPCG_REQ_STOP, 8'h5a);
        repeat (16)
            run_mode(2'($urandom_range(3, 1)), 8'($urandom));
        summarize();
    end
endmodule // low_power_clock_gating_test

// *** dv/lpcg_core_model.sv ***
// Processor core model that raises low-power mode requests.
// Assumes go is a one-cycle strobe from the bench, driven on a rising edge.
`timescale 1ns/100ps

module lpcg_core_model
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic [1:0] goMode,
    input wire logic modeAck,
    output logic [1:0] modeReq
);
    // Drop on ack, else Run would take the stale request again after wake
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            modeReq <= lpcg_pkg::LPCG_REQ_RUN;
        else if (modeAck)
            modeReq <= lpcg_pkg::LPCG_REQ_RUN;
        else if (go)
            modeReq <= goMode;
    end
endmodule // lpcg_core_model

// *** rtl/lpcg_pkg.sv ***
// Constants and carrier types for the low-power clock gating block.
// Assumes a single 100 MHz clock and an active-low asynchronous reset.
package lpcg_pkg;

    // ------------------------------------------------------------
    // Modes and timing
    // ------------------------------------------------------------
    localparam logic [1:0] LPCG_REQ_RUN = 2'h0;
    localparam logic [1:0] LPCG_REQ_WAIT = 2'h1;
    localparam logic [1:0] LPCG_REQ_PSTOP = 2'h2;
    localparam logic [1:0] LPCG_REQ_STOP = 2'h3;
    localparam int LPCG_BUS_DIV = 2;
    localparam int LPCG_PERIPH_N = 8;
    localparam logic [7:0] LPCG_PERIPH_RST = 8'hff;

    typedef enum logic [4:0]
    {
        LPCG_RUN = 5'h01,
        LPCG_WAIT = 5'h02,
        LPCG_PSTOP = 5'h04,
        LPCG_STOP = 5'h08,
        LPCG_ENTER = 5'h10
    } lpcg_state_t;

    typedef struct packed
    {
        logic cpuRun;
        logic busRun;
        logic oscRun;
    } lpcg_clk_en_t;

endpackage

// *** rtl/lpcg_top.sv ***
// Power mode sequencer and clock gating for the core clock tree.
// Assumes mode requests and wake are synchronous to clk.
`timescale 1ns/100ps

module lpcg_top
#(
    parameter int PERIPH_N = lpcg_pkg::LPCG_PERIPH_N
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] modeReq,
    input wire logic wakeEvent,
    input wire logic [PERIPH_N-1:0] waitPeriphKeep,
    output logic modeAck,
    output lpcg_pkg::lpcg_clk_en_t clkEn,
    output logic [PERIPH_N-1:0] periphClkEn,
    output logic busClockTick,
    output logic bus_clock_out,
    output logic crystal_input_en
);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    if (PERIPH_N < 1 || PERIPH_N > 8)
    begin : g_bad_n
        $error("PERIPH_N must be 1 to 8");
    end

    // Divider is a single phase flop, so only clk/2 is served
    if (lpcg_pkg::LPCG_BUS_DIV != 2)
    begin : g_bad_div
        $error("LPCG_BUS_DIV must be 2");
    end

    lpcg_pkg::lpcg_state_t state_q;
    lpcg_pkg::lpcg_state_t state_d;
    logic [1:0] target_q;
    logic busPhase_q;
    logic busRun;
    logic cpuRun_d;
    logic busRun_d;
    logic oscRun_d;
    logic ack_d;
    logic [PERIPH_N-1:0] periph_d;

    // ------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------
    // Entry waits for the high bus phase and leaves as the pin falls, so the pin never shows a runt
    assign busRun = (state_q == lpcg_pkg::LPCG_RUN)
        || (state_q == lpcg_pkg::LPCG_WAIT)
        || (state_q == lpcg_pkg::LPCG_ENTER);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            lpcg_pkg::LPCG_RUN:
            begin
                if (modeReq != lpcg_pkg::LPCG_REQ_RUN && !wakeEvent)
                    state_d = lpcg_pkg::LPCG_ENTER;
            end
            lpcg_pkg::LPCG_ENTER:
            begin
                if (wakeEvent)
                    state_d = lpcg_pkg::LPCG_RUN;
                else if (busPhase_q)
                begin
                    case (target_q)
                        lpcg_pkg::LPCG_REQ_WAIT:
                            state_d = lpcg_pkg::LPCG_WAIT;
                        lpcg_pkg::LPCG_REQ_PSTOP:
                            state_d = lpcg_pkg::LPCG_PSTOP;
                        lpcg_pkg::LPCG_REQ_STOP:
                            state_d = lpcg_pkg::LPCG_STOP;
                        default:
                            state_d = lpcg_pkg::LPCG_RUN;
                    endcase
                end
            end
            lpcg_pkg::LPCG_WAIT,
            lpcg_pkg::LPCG_PSTOP,
            lpcg_pkg::LPCG_STOP:
            begin
                if (wakeEvent)
                    state_d = lpcg_pkg::LPCG_RUN;
            end
            default:
                state_d = lpcg_pkg::LPCG_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state_q <= lpcg_pkg::LPCG_RUN;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            target_q <= lpcg_pkg::LPCG_REQ_RUN;
        else if (state_q == lpcg_pkg::LPCG_RUN)
            target_q <= modeReq;
    end

    // ------------------------------------------------------------
    // Bus clock divider and pin
    // ------------------------------------------------------------
    // Phase freezes low when gated, so restart begins with full high
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            busPhase_q <= 1'b0;
        else if (busRun)
            busPhase_q <= ~busPhase_q;
        else
            busPhase_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bus_clock_out <= 1'b0;
            busClockTick <= 1'b0;
        end
        else
        begin
            bus_clock_out <= busRun && !busPhase_q;
            busClockTick <= busRun && busPhase_q;
        end
    end

    // ------------------------------------------------------------
    // Next-value decode
    // ------------------------------------------------------------
    // Decoded from state_d so every enable lines up with state_q
    always_comb
    begin
        cpuRun_d = 1'b0;
        busRun_d = 1'b0;
        oscRun_d = 1'b1;
        ack_d = 1'b0;
        periph_d = '0;
        case (state_d)
            lpcg_pkg::LPCG_RUN,
            lpcg_pkg::LPCG_ENTER:
            begin
                cpuRun_d = (state_d == lpcg_pkg::LPCG_RUN);
                busRun_d = 1'b1;
                periph_d = {PERIPH_N{1'b1}};
            end
            lpcg_pkg::LPCG_WAIT:
            begin
                busRun_d = 1'b1;
                ack_d = 1'b1;
                periph_d = waitPeriphKeep;
            end
            lpcg_pkg::LPCG_PSTOP:
            begin
                ack_d = 1'b1;
            end
            lpcg_pkg::LPCG_STOP:
            begin
                oscRun_d = 1'b0;
                ack_d = 1'b1;
            end
            // Unreachable for one-hot state; fail safe to Run clocks
            default:
            begin
                cpuRun_d = 1'b1;
                busRun_d = 1'b1;
                periph_d = {PERIPH_N{1'b1}};
            end
        endcase
    end

    // ------------------------------------------------------------
    // Clock enables
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            clkEn <= '{cpuRun: 1'b1, busRun: 1'b1, oscRun: 1'b1};
            crystal_input_en <= 1'b1;
            modeAck <= 1'b0;
        end
        else
        begin
            clkEn.cpuRun <= cpuRun_d;
            clkEn.busRun <= busRun_d;
            clkEn.oscRun <= oscRun_d;
            crystal_input_en <= oscRun_d;
            modeAck <= ack_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            periphClkEn <= PERIPH_N'(lpcg_pkg::LPCG_PERIPH_RST);
        else
            periphClkEn <= periph_d;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_stop_osc_off: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == lpcg_pkg::LPCG_STOP |-> !crystal_input_en)
        else $error("oscillator running in stop");
    a_stop_pin_still: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == lpcg_pkg::LPCG_STOP)[*2] |-> $stable(bus_clock_out))
        else $error("bus clock toggles in stop");
    a_pstop_osc_on: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == lpcg_pkg::LPCG_PSTOP |-> crystal_input_en
            && !clkEn.busRun)
        else $error("pseudo stop gating wrong");
    a_wait_bus_runs: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == lpcg_pkg::LPCG_WAIT)[*3] |-> $changed(bus_clock_out))
        else $error("bus clock stalled in wait");
    a_wait_osc_cpu: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == lpcg_pkg::LPCG_WAIT |-> clkEn.oscRun && !clkEn.cpuRun)
        else $error("wait gating wrong");
    a_wake_to_run: assert property (@(posedge clk) disable iff (!rst_b)
        wakeEvent && state_q != lpcg_pkg::LPCG_RUN
            |=> state_q == lpcg_pkg::LPCG_RUN ##0 clkEn.cpuRun)
        else $error("wake did not return to run");
    a_no_runt_high: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(clkEn.busRun) |-> !bus_clock_out
            && $past(bus_clock_out))
        else $error("short bus clock pulse");
    a_pin_period: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(bus_clock_out) |=> !bus_clock_out)
        else $error("bus clock period wrong");
    a_wait_periph: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == lpcg_pkg::LPCG_WAIT && $stable(waitPeriphKeep)
            && $past(state_q) == lpcg_pkg::LPCG_WAIT
            |-> periphClkEn == waitPeriphKeep)
        else $error("peripheral gating wrong");

    // ------------------------------------------------------------
    // Assertions on gating, sequencing, handshake and pins
    // ------------------------------------------------------------
    a_run_all_on: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == lpcg_pkg::LPCG_RUN |-> clkEn.cpuRun && clkEn.busRun
            && clkEn.oscRun && crystal_input_en
            && periphClkEn == {PERIPH_N{1'b1}})
        else $error("run gating wrong");
    a_ack_modes: assert property (@(posedge clk) disable iff (!rst_b)
        modeAck == (state_q == lpcg_pkg::LPCG_WAIT
            || state_q == lpcg_pkg::LPCG_PSTOP
            || state_q == lpcg_pkg::LPCG_STOP))
        else $error("acknowledge out of step");
    a_ack_holds: assert property (@(posedge clk) disable iff (!rst_b)
        modeAck && !wakeEvent |=> modeAck)
        else $error("acknowledge dropped early");
    a_target_held: assert property (@(posedge clk) disable iff (!rst_b)
        state_q != lpcg_pkg::LPCG_RUN |=> $stable(target_q))
        else $error("target changed outside run");
    a_enter_short: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == lpcg_pkg::LPCG_ENTER
            |-> ##[1:2] state_q != lpcg_pkg::LPCG_ENTER)
        else $error("entry stalled");
    a_wake_abort: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == lpcg_pkg::LPCG_ENTER && wakeEvent
            |=> state_q == lpcg_pkg::LPCG_RUN)
        else $error("wake did not abort entry");
    a_gated_pin_low: assert property (@(posedge clk) disable iff (!rst_b)
        !clkEn.busRun |-> !bus_clock_out)
        else $error("bus clock high while gated");
    a_restart_full: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(clkEn.busRun) |=> bus_clock_out)
        else $error("bus clock restart late");
    a_tick_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        busClockTick |=> !busClockTick)
        else $error("bus tick too long");
    a_tick_low_half: assert property (@(posedge clk) disable iff (!rst_b)
        busClockTick |-> !bus_clock_out)
        else $error("bus tick in high half");
    a_stop_all_off: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == lpcg_pkg::LPCG_STOP |-> !clkEn.cpuRun
            && !clkEn.busRun && !clkEn.oscRun
            && periphClkEn == '0)
        else $error("stop gating wrong");
    a_pstop_periph: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == lpcg_pkg::LPCG_PSTOP |-> !clkEn.cpuRun
            && periphClkEn == '0)
        else $error("pseudo stop peripherals clocked");
    a_osc_pin_match: assert property (@(posedge clk) disable iff (!rst_b)
        crystal_input_en == clkEn.oscRun)
        else $error("oscillator enables disagree");
    a_wait_bus_en: assert property (@(posedge clk) disable iff (!rst_b)
        state_q == lpcg_pkg::LPCG_WAIT |-> clkEn.busRun)
        else $error("bus clock gated in wait");

endmodule // lpcg_top
